// ### hw/totk_pkg.sv
package totk_pkg;

   // Register map, printed offsets
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] TONE_CTRL_ADDR = 12'h038;
   localparam logic [ADDR_W-1:0] TICK_CTRL_ADDR = 12'h039;
   localparam logic [7:0] TONE_CTRL_RST = 8'h00;
   localparam logic [7:0] TICK_CTRL_RST = 8'h00;

   // Field positions
   localparam int TONE_SEL_LSB = 0;
   localparam int TONE_SEL_W = 2;
   localparam int TONE_EN_BIT = 2;
   localparam int TICK_SEL_LSB = 0;
   localparam int TICK_SEL_W = 3;
   localparam int TICK_EN_BIT = 3;

   // Divider chain widths
   localparam int GDIV_W = 22;
   localparam int SDIV_W = 15;
   localparam int LF_SYNC_N = 3;

   // Divide ratios as powers of two
   localparam int TONE_G_LOG2 [4] = '{12, 11, 10, 9};
   localparam int TONE_S_LOG2 [4] = '{5, 4, 3, 0};
   localparam int TICK_G_LOG2 [8] = '{22, 20, 15, 13, 12, 11, 10, 8};
   localparam int TICK_S_LOG2 [8] = '{15, 13, 8, 6, 5, 4, 3, 0};
   localparam logic [1:0] TONE_SEL_RSVD = 2'h3;
   localparam logic [2:0] TICK_SEL_RSVD = 3'h7;
   localparam logic [2:0] TICK_SLOW_MAX = 3'h1;

   // Operating modes of the chip
   typedef enum logic [2:0] {
      TOTK_NORMAL = 3'h0,
      TOTK_IDLE1 = 3'h1,
      TOTK_IDLE_TBT_ONLY_MODE = 3'h3,
      TOTK_SLOW = 3'h2,
      TOTK_SLEEP1 = 3'h6,
      TOTK_SLEEP_TBT_ONLY_MODE = 3'h7,
      TOTK_STOP = 3'h5
   } totk_mode_e;

   // Software port
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } totk_bus_s;

   // Whole block state
   typedef struct packed {
      logic tone_en;
      logic [TONE_SEL_W-1:0] tone_sel;
      logic tick_en;
      logic [TICK_SEL_W-1:0] tick_sel;
      logic [GDIV_W-1:0] gdiv;
      logic [SDIV_W-1:0] sdiv;
      logic [LF_SYNC_N-1:0] lf_sync;
      logic lf_lvl;
      logic tick_tap_q;
      totk_mode_e mode_q;
      logic tone_pin;
      logic tick_irq;
      logic [7:0] rd_data;
   } totk_state_s;

endpackage

// ### hw/totk_top.sv
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ns

// Behaviour
// - Enabled tone pin carries square wave at selected frequency.
// - Disabled tone pin stops toggling and holds high.
// - Gear source tone codes divide by 2^12, 2^11, 2^10, 2^9.
// - Slow source tone codes divide by 2^5, 2^4, 2^3; 11 reserved.
// - Entering stop or tick-only modes clears tone enable, keeps select.
// - Tone divider runs always; first and last periods may be short.
// - Tone control bits 7 to 3 read zero.
// - Slow source in normal or idle resynchronised; tone may jitter.
// - Tone frequency may deviate while switching normal and slow.
// - Gear source tick codes divide by 2^22 down to 2^8.
// - Slow source tick codes 2^15 to 2^3; slow modes 000, 001 only.
// - Tick enabled raises request each tap falling edge; else none.
// - Tick divider runs always; first request may come early.
// - Entering stop clears tick enable and keeps tick select.
// - Slow source in normal or idle resynchronised; tick may jitter.
// - Tick control bits 7 to 4 read zero.
module totk_top (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Register port
   input wire logic [totk_pkg::ADDR_W-1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rd_data_o,
   // Chip mode and clock source
   input wire totk_pkg::totk_mode_e mode_i,
   input wire logic slow_source_sel_i,
   input wire logic low_freq_clk_i,
   // Buzzer and interrupt
   output logic tone_out_pin_o,
   output logic tick_irq_o
);

   totk_pkg::totk_state_s s_r;
   totk_pkg::totk_state_s s_nxt;
   totk_pkg::totk_bus_s bus;
   logic use_slow;
   logic slow_mode;
   logic tone_tap;
   logic tick_tap;
   logic tone_kill;
   logic tick_kill;
   logic lf_rise;

   assign bus.addr = addr_i;
   assign bus.wdata = wdata_i;
   assign bus.wr = wr_i;
   assign bus.rd = rd_i;

   // Modes running from the low-frequency clock
   function automatic logic is_slow_mode(
      input totk_pkg::totk_mode_e m
   );
      is_slow_mode = (m == totk_pkg::TOTK_SLOW) ||
         (m == totk_pkg::TOTK_SLEEP1) ||
         (m == totk_pkg::TOTK_SLEEP_TBT_ONLY_MODE);
   endfunction

   // Modes that force the tone off
   function automatic logic is_tone_off_mode(
      input totk_pkg::totk_mode_e m
   );
      is_tone_off_mode = (m == totk_pkg::TOTK_STOP) ||
         (m == totk_pkg::TOTK_IDLE_TBT_ONLY_MODE) ||
         (m == totk_pkg::TOTK_SLEEP_TBT_ONLY_MODE);
   endfunction

   // Pick a divider bit for a power-of-two ratio
   function automatic logic tap_g(
      input logic [totk_pkg::GDIV_W-1:0] d,
      input int lg
   );
      tap_g = d[lg-1];
   endfunction

   function automatic logic tap_s(
      input logic [totk_pkg::SDIV_W-1:0] d,
      input int lg
   );
      tap_s = d[lg-1];
   endfunction

   // Source selection
   always_comb begin
      slow_mode = is_slow_mode(mode_i);
      use_slow = slow_source_sel_i || slow_mode;
   end

   // Tone tap
   always_comb begin
      if (use_slow) begin
         if (s_r.tone_sel == totk_pkg::TONE_SEL_RSVD) begin
            tone_tap = 1'b1;
         end else begin
            tone_tap = tap_s(s_r.sdiv,
               totk_pkg::TONE_S_LOG2[s_r.tone_sel]);
         end
      end else begin
         tone_tap = tap_g(s_r.gdiv,
            totk_pkg::TONE_G_LOG2[s_r.tone_sel]);
      end
   end

   // Tick tap
   always_comb begin
      if (use_slow) begin
         if (s_r.tick_sel == totk_pkg::TICK_SEL_RSVD) begin
            tick_tap = 1'b0;
         end else if (slow_mode &&
            s_r.tick_sel > totk_pkg::TICK_SLOW_MAX) begin
            tick_tap = 1'b0;
         end else begin
            tick_tap = tap_s(s_r.sdiv,
               totk_pkg::TICK_S_LOG2[s_r.tick_sel]);
         end
      end else begin
         tick_tap = tap_g(s_r.gdiv,
            totk_pkg::TICK_G_LOG2[s_r.tick_sel]);
      end
   end

   // Mode entry detection
   always_comb begin
      tone_kill = is_tone_off_mode(mode_i) &&
         (mode_i != s_r.mode_q);
      tick_kill = (mode_i == totk_pkg::TOTK_STOP) &&
         (s_r.mode_q != totk_pkg::TOTK_STOP);
   end

   // Low-frequency edge after three-stage filter
   assign lf_rise = ~s_r.lf_lvl &&
      (s_r.lf_sync[1] == s_r.lf_sync[2]) && s_r.lf_sync[2];

   // Next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.mode_q = mode_i;

      // Free-running chains
      s_nxt.gdiv = s_r.gdiv + 1'b1;
      s_nxt.lf_sync = {s_r.lf_sync[1:0], low_freq_clk_i};
      if (s_r.lf_sync[1] == s_r.lf_sync[2]) begin
         s_nxt.lf_lvl = s_r.lf_sync[2];
      end
      if (lf_rise) begin
         s_nxt.sdiv = s_r.sdiv + 1'b1;
      end

      // Register writes
      if (bus.wr && bus.addr == totk_pkg::TONE_CTRL_ADDR) begin
         s_nxt.tone_en = bus.wdata[totk_pkg::TONE_EN_BIT];
         s_nxt.tone_sel = bus.wdata[totk_pkg::TONE_SEL_LSB +:
            totk_pkg::TONE_SEL_W];
      end
      if (bus.wr && bus.addr == totk_pkg::TICK_CTRL_ADDR) begin
         s_nxt.tick_en = bus.wdata[totk_pkg::TICK_EN_BIT];
         s_nxt.tick_sel = bus.wdata[totk_pkg::TICK_SEL_LSB +:
            totk_pkg::TICK_SEL_W];
      end

      // Mode entry overrides a write
      if (tone_kill) begin
         s_nxt.tone_en = 1'b0;
      end
      if (tick_kill) begin
         s_nxt.tick_en = 1'b0;
      end

      // Tone pin
      if (s_r.tone_en) begin
         s_nxt.tone_pin = tone_tap;
      end else begin
         s_nxt.tone_pin = 1'b1;
      end

      // Tick pulse on falling edge of tap
      s_nxt.tick_tap_q = tick_tap;
      s_nxt.tick_irq = s_r.tick_en && s_r.tick_tap_q &&
         ~tick_tap;

      // Read data for next cycle
      s_nxt.rd_data = 8'h00;
      if (bus.rd) begin
         case (bus.addr)
            totk_pkg::TONE_CTRL_ADDR: begin
               s_nxt.rd_data[totk_pkg::TONE_EN_BIT] =
                  s_r.tone_en;
               s_nxt.rd_data[totk_pkg::TONE_SEL_LSB +:
                  totk_pkg::TONE_SEL_W] = s_r.tone_sel;
            end
            totk_pkg::TICK_CTRL_ADDR: begin
               s_nxt.rd_data[totk_pkg::TICK_EN_BIT] =
                  s_r.tick_en;
               s_nxt.rd_data[totk_pkg::TICK_SEL_LSB +:
                  totk_pkg::TICK_SEL_W] = s_r.tick_sel;
            end
            default: begin
               s_nxt.rd_data = 8'h00;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         s_r <= '0;
         s_r.tone_pin <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rd_data_o = s_r.rd_data;
   assign tone_out_pin_o = s_r.tone_pin;
   assign tick_irq_o = s_r.tick_irq;

   // Checks

   AST_TONE_OFF_HIGH: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !s_r.tone_en |=> tone_out_pin_o)
      else $error("tone pin not high while disabled");

   AST_TONE_FOLLOWS: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      s_r.tone_en |=> tone_out_pin_o == $past(tone_tap))
      else $error("tone pin does not follow divider tap");

   AST_TONE_GEAR_TAP: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !use_slow && s_r.tone_sel == 2'h0 |->
      tone_tap == s_r.gdiv[11])
      else $error("gear tone tap wrong");

   AST_TICK_NONE: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !s_r.tick_en |=> !tick_irq_o)
      else $error("tick request while disabled");

   AST_TICK_EDGE: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      s_r.tick_en && s_r.tick_tap_q && !tick_tap |=>
      tick_irq_o)
      else $error("tick request missed on falling edge");

   AST_TICK_PULSE: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      tick_irq_o |=> !tick_irq_o)
      else $error("tick request wider than one cycle");

   AST_TONE_KILL: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      tone_kill |=> !s_r.tone_en &&
      s_r.tone_sel == $past(s_r.tone_sel) ##1 tone_out_pin_o)
      else $error("tone not cleared on mode entry");

   AST_TICK_KILL: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      tick_kill |=> !s_r.tick_en &&
      s_r.tick_sel == $past(s_r.tick_sel))
      else $error("tick enable not cleared on stop");

   AST_TONE_RD: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      rd_i && addr_i == totk_pkg::TONE_CTRL_ADDR |=>
      rd_data_o[7:3] == 5'h00 &&
      rd_data_o[2:0] == {$past(s_r.tone_en), $past(s_r.tone_sel)})
      else $error("tone control read wrong");

   AST_TICK_RD: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      rd_i && addr_i == totk_pkg::TICK_CTRL_ADDR |=>
      rd_data_o[7:4] == 4'h0 &&
      rd_data_o[3:0] == {$past(s_r.tick_en), $past(s_r.tick_sel)})
      else $error("tick control read wrong");

   AST_GEAR_RUNS: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      1'b1 |=> s_r.gdiv ==
      totk_pkg::GDIV_W'($past(s_r.gdiv) + 1'b1))
      else $error("gear divider stalled");

   AST_SLOW_STEP: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !lf_rise |=> s_r.sdiv == $past(s_r.sdiv))
      else $error("slow divider moved without edge");

   AST_RD_IDLE: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !rd_i |=> rd_data_o == 8'h00)
      else $error("read data not zero outside a read");

   AST_TONE_RSVD: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      s_r.tone_en && use_slow &&
      s_r.tone_sel == totk_pkg::TONE_SEL_RSVD |=> tone_out_pin_o)
      else $error("reserved slow tone code not high");

   AST_TONE_SLOW_TAP: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      use_slow && s_r.tone_sel == 2'h0 |->
      tone_tap == s_r.sdiv[totk_pkg::TONE_S_LOG2[0]-1])
      else $error("slow tone tap wrong");

   AST_TICK_GEAR_TAP: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !use_slow && s_r.tick_sel == 3'h7 |->
      tick_tap == s_r.gdiv[totk_pkg::TICK_G_LOG2[7]-1])
      else $error("gear tick tap wrong");

   AST_TICK_SLOW_NONE: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      slow_mode && s_r.tick_sel > totk_pkg::TICK_SLOW_MAX |->
      !tick_tap)
      else $error("slow mode tick tap not silenced");

   AST_TICK_RSVD: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      use_slow && s_r.tick_sel == totk_pkg::TICK_SEL_RSVD |->
      !tick_tap)
      else $error("reserved slow tick code produced a tap");

   AST_SDIV_STEP: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      lf_rise |=> s_r.sdiv ==
      totk_pkg::SDIV_W'($past(s_r.sdiv) + 1'b1))
      else $error("slow divider missed an edge");

   AST_RST_VALUES: assert property (
      @(posedge mclk_i)
      rst_i && $past(rst_i) |-> tone_out_pin_o && !tick_irq_o &&
      rd_data_o == 8'h00)
      else $error("outputs not at reset values");

endmodule

// ### verif/totk_periph_model.sv
`timescale 1ns/1ns
// Buzzer and interrupt monitor, measuring pin and request timing
module totk_periph_model (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Observed lines
   input wire logic tone_pin_i,
   input wire logic tick_irq_i,
   // Measurements
   output int tone_half_o,
   output int tone_flips_o,
   output int tick_gap_o,
   output int tick_cnt_o,
   output int tick_wide_o
);
   int since_flip;
   int since_tick;
   logic pin_q;
   logic irq_q;
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         {since_flip, since_tick, tone_flips_o, tick_cnt_o} <= '0;
         {tone_half_o, tick_gap_o, tick_wide_o} <= '0;
         pin_q <= 1'b1;
         irq_q <= 1'b0;
      end else begin
         pin_q <= tone_pin_i;
         irq_q <= tick_irq_i;
         since_flip <= since_flip + 1;
         since_tick <= since_tick + 1;
         if (tone_pin_i !== pin_q) begin
            tone_half_o <= since_flip;
            since_flip <= 1;
            tone_flips_o <= tone_flips_o + 1;
         end
         if (tick_irq_i === 1'b1 && irq_q !== 1'b1) begin
            tick_gap_o <= since_tick;
            since_tick <= 1;
            tick_cnt_o <= tick_cnt_o + 1;
         end
         if (tick_irq_i === 1'b1 && irq_q === 1'b1) begin
            tick_wide_o <= tick_wide_o + 1;
         end
      end
   end
endmodule

// ### verif/testbench.sv
`timescale 1ns/1ns
module testbench;
   logic mclk_i;
   logic rst_i;
   logic [totk_pkg::ADDR_W-1:0] addr_i;
   logic [7:0] wdata_i;
   logic wr_i;
   logic rd_i;
   logic [7:0] rd_data_o;
   totk_pkg::totk_mode_e mode_i;
   logic slow_source_sel_i;
   logic low_freq_clk_i;
   logic tone_out_pin_o;
   logic tick_irq_o;
   int tone_half, tone_flips, tick_gap, tick_cnt, tick_wide;
   int n_errors;
   int check_count;
   int c;
   int d;
   logic [7:0] mreg [2];
   int tl [4] = '{12, 11, 10, 9};
   int tg [8] = '{22, 20, 15, 13, 12, 11, 10, 8};
   int sl [3] = '{5, 4, 3};
   totk_pkg::totk_mode_e ml [3] = '{totk_pkg::TOTK_IDLE_TBT_ONLY_MODE,
      totk_pkg::TOTK_SLEEP_TBT_ONLY_MODE, totk_pkg::TOTK_STOP};
   localparam logic [11:0] TN = totk_pkg::TONE_CTRL_ADDR;
   localparam logic [11:0] TK = totk_pkg::TICK_CTRL_ADDR;

   totk_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
      .mode_i(mode_i), .slow_source_sel_i(slow_source_sel_i),
      .low_freq_clk_i(low_freq_clk_i), .tone_out_pin_o(tone_out_pin_o),
      .tick_irq_o(tick_irq_o));
   totk_periph_model peer (.mclk_i(mclk_i), .rst_i(rst_i),
      .tone_pin_i(tone_out_pin_o), .tick_irq_i(tick_irq_o),
      .tone_half_o(tone_half), .tone_flips_o(tone_flips),
      .tick_gap_o(tick_gap), .tick_cnt_o(tick_cnt), .tick_wide_o(tick_wide));

   initial begin
      mclk_i = 1'b0;
      forever #10 mclk_i = ~mclk_i;
   end
   initial begin
      low_freq_clk_i = 1'b0;
      #7;
      forever #165 low_freq_clk_i = ~low_freq_clk_i;
   end

   task automatic summarize;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s exp %0h seen %0h", nm, exp, seen);
      end
   endtask

   function automatic logic [7:0] mix(input logic [3:0] lo);
      logic [31:0] r;
      r = $urandom();
      return {r[7:4], lo};
   endfunction

   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
      if (a == TN) mreg[0] = v & 8'h07;
      if (a == TK) mreg[1] = v & 8'h0F;
   endtask

   task automatic rd(input logic [11:0] a, input int i, input string nm);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 chk(nm, rd_data_o, (i < 0) ? 8'h00 : mreg[i]);
   endtask

   task automatic wait_ev(input int sel, input int n);
      int s0;
      int k;
      s0 = sel ? tick_cnt : tone_flips;
      for (k = 0; k < 40000 && (sel ? tick_cnt : tone_flips) < s0 + n; k++)
         @(posedge mclk_i);
      if (k >= 40000) begin
         n_errors++;
         $display("BAD wait%0d exp %0d seen %0d", sel, n, 0);
         summarize();
      end
   endtask

   task automatic quiet(input int sel, input int cyc, input string nm);
      int s0;
      repeat (2) @(posedge mclk_i);
      s0 = sel ? tick_cnt : tone_flips;
      repeat (cyc) @(posedge mclk_i);
      chk(nm, sel ? tick_cnt : tone_flips, s0);
   endtask

   initial begin
      void'($urandom(32'h0129FFAC));
      {rst_i, addr_i, wdata_i, wr_i, rd_i} = {1'b1, 22'h000000};
      mode_i = totk_pkg::TOTK_NORMAL;
      slow_source_sel_i = 1'b0;
      {n_errors, check_count} = '0;
      mreg[0] = 8'h00;
      mreg[1] = 8'h00;
      repeat (12) @(posedge mclk_i);
      rst_i <= 1'b0;
      #1 chk("pin_rst", tone_out_pin_o, 1);
      rd(TN, 0, "tone_rst");
      rd(TK, 1, "tick_rst");
      rd(12'h03A, -1, "unmapped");
      for (c = 0; c < 4; c++) begin
         wr(TN, mix(4'h4 | 4'(c)));
         rd(TN, 0, "tone_reg");
         wait_ev(0, 3);
         chk("tone_half", tone_half, 1 << (tl[c] - 1));
      end
      wr(TN, mix(4'h3));
      @(posedge mclk_i);
      #1 chk("pin_off", tone_out_pin_o, 1);
      quiet(0, 600, "tone_off");
      for (c = 7; c >= 3; c--) begin
         wr(TK, mix(4'(c)));
         wr(TK, mix(4'h8 | 4'(c)));
         rd(TK, 1, "tick_reg");
         wait_ev(1, 2);
         chk("tick_gap", tick_gap, 1 << tg[c]);
         chk("tick_wide", tick_wide, 0);
      end
      wr(TK, mix(4'h7));
      quiet(1, 600, "tick_off");
      for (c = 0; c < 3; c++) begin
         wr(TN, 8'h07);
         wr(TK, 8'h0F);
         @(posedge mclk_i);
         mode_i <= ml[c];
         mreg[0][2] = 1'b0;
         if (ml[c] == totk_pkg::TOTK_STOP) mreg[1][3] = 1'b0;
         rd(TN, 0, "tone_mode");
         rd(TK, 1, "tick_mode");
         chk("pin_mode", tone_out_pin_o, 1);
         @(posedge mclk_i);
         mode_i <= totk_pkg::TOTK_NORMAL;
      end
      wr(TK, 8'h00);
      slow_source_sel_i <= 1'b1;
      for (c = 0; c < 3; c++) begin
         wr(TN, mix(4'h4 | 4'(c)));
         wait_ev(0, 3);
         d = tone_half - (330 << (sl[c] - 1)) / 20;
         chk("slow_half", d <= 2 && d >= -2, 1);
      end
      wr(TN, mix(4'h7));
      repeat (4) @(posedge mclk_i);
      quiet(0, 1500, "tone_rsvd");
      chk("pin_rsvd", tone_out_pin_o, 1);
      @(posedge mclk_i);
      mode_i <= totk_pkg::TOTK_SLOW;
      wr(TK, mix(4'h2));
      wr(TK, mix(4'hA));
      quiet(1, 9000, "tick_slow");
      wr(TK, 8'h02);
      mode_i <= totk_pkg::TOTK_NORMAL;
      wr(TK, 8'h06);
      wr(TK, 8'h0E);
      wait_ev(1, 2);
      d = tick_gap - (330 << 3) / 20;
      chk("slow_tick_gap", d <= 2 && d >= -2, 1);
      rst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      mreg[0] = 8'h00;
      mreg[1] = 8'h00;
      #1 chk("pin_rst2", tone_out_pin_o, 1);
      rd(TN, 0, "tone_rst2");
      rd(TK, 1, "tick_rst2");
      summarize();
   end
endmodule
